/* File: pdc_regs.sv */
/*
  Configuration register bank of a fractional-N synthesizer, reached over
  AXI4-Lite. Drives the divider, modulator and reference path settings.
  Assumes a single 100 MHz clock, synchronous active-low reset and a master
  that keeps at most one write and one read in flight.
*/
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps

// Behaviour
// - Power field: 0 forced down, 1 forced up, 2 follows chip-enable, 3 reserved
// - Power field resets to 0, device powered down regardless of chip-enable
// - Writing 1 to soft reset bit restores all registers to defaults
// - Every field holds its default from reset until software writes it
// - Feedback divide is 18 bits across three registers, default 16
// - Writing the lowest feedback divide register starts ramp execution
// - Dither and order fields decode as documented, both reset to 0
// - Denominator used only with ramping off; otherwise fixed two to 24th
// - Reference divide is 16 bits, default 1; value 1 bypasses the counter
// - Doubler enable inserts doubler ahead of reference divider, resets 0
module pdc_regs
  import pdc_pkg::*;
(
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Chip-enable pin
  input  wire logic                 chip_enable,
  // Synthesizer settings
  output logic                      power_up,
  output logic [FB_DIV_W-1:0]       feedback_divide,
  output logic                      ramp_start,
  output logic                      ramp_enable,
  output logic [1:0]                modulator_dither_level,
  output logic [2:0]                modulator_order_select,
  output logic                      modulator_order_reserved,
  output logic [FRAC_W-1:0]         fraction_numerator,
  output logic [FRAC_W:0]           effective_denominator,
  output logic [REF_DIV_W-1:0]      reference_divide,
  output logic                      reference_bypass,
  output logic                      reference_doubler_enable
);

  // ==========================================================================
  // Register storage
  logic [1:0]            power_state_select_ff;
  logic [FB_DIV_W-1:0]   fb_div_ff;
  logic [1:0]            dither_ff;
  logic [2:0]            order_ff;
  logic [FRAC_W-1:0]     num_ff;
  logic [FRAC_W-1:0]     den_ff;
  logic [REF_DIV_W-1:0]  ref_div_ff;
  logic [7:0]            ref_ctrl_ff;
  logic                  ramp_en_ff;
  logic                  ramp_start_ff;

  // ==========================================================================
  // Write channel: address and data taken in either order
  logic        aw_held_ff;
  logic [7:0]  aw_addr_ff;
  logic        w_held_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        wr_go;
  logic [7:0]  wr_idx;
  logic        wr_hit;
  logic [7:0]  wbyte;
  logic        soft_rst;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign wr_go         = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_idx        = {2'h0, aw_addr_ff[7:2]};
  // Narrow registers live in byte lane 0; a write without that lane changes nothing
  assign wbyte         = w_data_ff[7:0];

  always_comb begin
    unique case (wr_idx)
      IDX_POWER_AND_SOFT_RESET, IDX_FEEDBACK_DIVIDE_LOW, IDX_FEEDBACK_DIVIDE_MID,
      IDX_FEEDBACK_HIGH_AND_MODULATOR, IDX_FRACTION_NUMERATOR_LOW,
      IDX_FRACTION_NUMERATOR_MID, IDX_FRACTION_NUMERATOR_HIGH,
      IDX_FRACTION_DENOMINATOR_LOW, IDX_FRACTION_DENOMINATOR_MID,
      IDX_FRACTION_DENOMINATOR_HIGH, IDX_REFERENCE_DIVIDE_LOW,
      IDX_REFERENCE_DIVIDE_HIGH, IDX_REFERENCE_PATH_CONTROL,
      IDX_RAMP_CONTROL: wr_hit = 1'b1;
      default:          wr_hit = 1'b0;
    endcase
  end

  logic wr_en;
  assign wr_en    = wr_go && wr_hit && w_strb_ff[0];
  assign soft_rst = wr_en && (wr_idx == IDX_POWER_AND_SOFT_RESET) && wbyte[SOFT_RESET_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // ==========================================================================
  // Register updates; soft reset outranks the store of its own write
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      power_state_select_ff <= PWR_SEL_RST;
      fb_div_ff             <= FB_DIV_RST;
      dither_ff             <= DITHER_RST;
      order_ff              <= ORDER_RST;
      num_ff                <= FRACTION_NUMERATOR_RST;
      den_ff                <= FRACTION_DENOMINATOR_RST;
      ref_div_ff            <= REF_DIV_RST;
      ref_ctrl_ff           <= 8'h00;
      ramp_en_ff            <= 1'b0;
    end else if (wr_en) begin
      unique case (wr_idx)
        IDX_POWER_AND_SOFT_RESET:        power_state_select_ff <= wbyte[1:0];
        IDX_FEEDBACK_DIVIDE_LOW:         fb_div_ff[7:0]   <= wbyte;
        IDX_FEEDBACK_DIVIDE_MID:         fb_div_ff[15:8]  <= wbyte;
        IDX_FEEDBACK_HIGH_AND_MODULATOR: begin
          fb_div_ff[17:16] <= wbyte[FB_HIGH_LSB +: 2];
          dither_ff        <= wbyte[DITHER_LSB +: 2];
          order_ff         <= wbyte[ORDER_LSB +: 3];
        end
        IDX_FRACTION_NUMERATOR_LOW:      num_ff[7:0]      <= wbyte;
        IDX_FRACTION_NUMERATOR_MID:      num_ff[15:8]     <= wbyte;
        IDX_FRACTION_NUMERATOR_HIGH:     num_ff[23:16]    <= wbyte;
        IDX_FRACTION_DENOMINATOR_LOW:    den_ff[7:0]      <= wbyte;
        IDX_FRACTION_DENOMINATOR_MID:    den_ff[15:8]     <= wbyte;
        IDX_FRACTION_DENOMINATOR_HIGH:   den_ff[23:16]    <= wbyte;
        IDX_REFERENCE_DIVIDE_LOW:        ref_div_ff[7:0]  <= wbyte;
        IDX_REFERENCE_DIVIDE_HIGH:       ref_div_ff[15:8] <= wbyte;
        IDX_REFERENCE_PATH_CONTROL:      ref_ctrl_ff      <= wbyte;
        IDX_RAMP_CONTROL:                ramp_en_ff       <= wbyte[RAMP_EN_BIT];
        default: ;
      endcase
    end
  end

  // Ramp start pulses for one cycle after a write to the lowest divide register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp_start_ff <= 1'b0;
    end else begin
      ramp_start_ff <= wr_en && (wr_idx == IDX_FEEDBACK_DIVIDE_LOW);
    end
  end

  // ==========================================================================
  // Read channel
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [7:0]  rd_idx;
  logic [7:0]  rd_byte;
  logic        rd_hit;

  assign s_axi_arready = !rvalid_ff;
  assign rd_idx        = {2'h0, s_axi_araddr[7:2]};

  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    unique case (rd_idx)
      IDX_POWER_AND_SOFT_RESET:        rd_byte = {6'h00, power_state_select_ff};
      IDX_FEEDBACK_DIVIDE_LOW:         rd_byte = fb_div_ff[7:0];
      IDX_FEEDBACK_DIVIDE_MID:         rd_byte = fb_div_ff[15:8];
      IDX_FEEDBACK_HIGH_AND_MODULATOR: rd_byte = {1'b0, order_ff, dither_ff, fb_div_ff[17:16]};
      IDX_FRACTION_NUMERATOR_LOW:      rd_byte = num_ff[7:0];
      IDX_FRACTION_NUMERATOR_MID:      rd_byte = num_ff[15:8];
      IDX_FRACTION_NUMERATOR_HIGH:     rd_byte = num_ff[23:16];
      IDX_FRACTION_DENOMINATOR_LOW:    rd_byte = den_ff[7:0];
      IDX_FRACTION_DENOMINATOR_MID:    rd_byte = den_ff[15:8];
      IDX_FRACTION_DENOMINATOR_HIGH:   rd_byte = den_ff[23:16];
      IDX_REFERENCE_DIVIDE_LOW:        rd_byte = ref_div_ff[7:0];
      IDX_REFERENCE_DIVIDE_HIGH:       rd_byte = ref_div_ff[15:8];
      IDX_REFERENCE_PATH_CONTROL:      rd_byte = ref_ctrl_ff;
      IDX_RAMP_CONTROL:                rd_byte = {7'h00, ramp_en_ff};
      default:                         rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h000000, rd_byte};
      rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // ==========================================================================
  // Decoded settings; reserved power code keeps the device down
  always_comb begin
    unique case (power_state_select_ff)
      PWR_FORCE_DOWN: power_up = 1'b0;
      PWR_FORCE_UP:   power_up = 1'b1;
      PWR_FOLLOW_PIN: power_up = chip_enable;
      default:        power_up = 1'b0;
    endcase
  end

  assign feedback_divide          = fb_div_ff;
  assign ramp_start               = ramp_start_ff;
  assign ramp_enable              = ramp_en_ff;
  assign modulator_dither_level   = dither_ff;
  assign modulator_order_select   = order_ff;
  assign modulator_order_reserved = order_ff > ORDER_MAX;
  assign fraction_numerator       = num_ff;
  assign effective_denominator    = ramp_en_ff ? FIXED_DEN : {1'b0, den_ff};
  assign reference_divide         = ref_div_ff;
  assign reference_bypass         = ref_div_ff == REF_DIV_RST;
  assign reference_doubler_enable = ref_ctrl_ff[DOUBLER_BIT];

  // ==========================================================================
  // Checks
  a_power_force_down: assert property (@(posedge aclk) disable iff (!aresetn)
    power_state_select_ff == PWR_FORCE_DOWN |-> !power_up)
    else $error("power up while forced down");

  a_power_follow_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    power_state_select_ff == PWR_FOLLOW_PIN |-> power_up == chip_enable)
    else $error("power does not follow chip enable");

  a_reset_power_down: assert property (@(posedge aclk)
    !aresetn |=> !power_up && feedback_divide == FB_DIV_RST)
    else $error("defaults not loaded by reset");

  a_soft_reset_defaults: assert property (@(posedge aclk) disable iff (!aresetn)
    soft_rst |=> feedback_divide == FB_DIV_RST && reference_divide == REF_DIV_RST
      && fraction_numerator == FRACTION_NUMERATOR_RST && !reference_doubler_enable)
    else $error("soft reset left a field changed");

  a_fields_hold_value: assert property (@(posedge aclk) disable iff (!aresetn)
    !wr_en |=> $stable(feedback_divide) && $stable(fraction_numerator))
    else $error("field changed without a write");

  a_ramp_start_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && wr_idx == IDX_FEEDBACK_DIVIDE_LOW && !soft_rst
      |=> ramp_start ##1 !ramp_start)
    else $error("ramp start not a single pulse");

  // Checks the shape of the fixed value, so a wrong constant is caught too
  a_fixed_denominator: assert property (@(posedge aclk) disable iff (!aresetn)
    ramp_enable |-> effective_denominator[FRAC_W] && effective_denominator[FRAC_W-1:0] == '0)
    else $error("denominator not fixed while ramping");

  a_low_byte_order: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && wr_idx == IDX_FRACTION_NUMERATOR_LOW
      |=> fraction_numerator[7:0] == $past(wbyte))
    else $error("low register not in low bits");

endmodule // pdc_regs

/* File: pdc_pkg.sv */
/*
  Package for the divider configuration register bank: register indices,
  field positions, reset values and codes.
  Assumes a 32-bit AXI4-Lite bus; each 8-bit register takes one aligned word.
*/
package pdc_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_POWER_AND_SOFT_RESET        = 8'h02;
  localparam logic [7:0] IDX_FEEDBACK_DIVIDE_LOW         = 8'h10;
  localparam logic [7:0] IDX_FEEDBACK_DIVIDE_MID         = 8'h11;
  localparam logic [7:0] IDX_FEEDBACK_HIGH_AND_MODULATOR = 8'h12;
  localparam logic [7:0] IDX_FRACTION_NUMERATOR_LOW      = 8'h13;
  localparam logic [7:0] IDX_FRACTION_NUMERATOR_MID      = 8'h14;
  localparam logic [7:0] IDX_FRACTION_NUMERATOR_HIGH     = 8'h15;
  localparam logic [7:0] IDX_FRACTION_DENOMINATOR_LOW    = 8'h16;
  localparam logic [7:0] IDX_FRACTION_DENOMINATOR_MID    = 8'h17;
  localparam logic [7:0] IDX_FRACTION_DENOMINATOR_HIGH   = 8'h18;
  localparam logic [7:0] IDX_REFERENCE_DIVIDE_LOW        = 8'h19;
  localparam logic [7:0] IDX_REFERENCE_DIVIDE_HIGH       = 8'h1A;
  localparam logic [7:0] IDX_REFERENCE_PATH_CONTROL      = 8'h1B;
  localparam logic [7:0] IDX_RAMP_CONTROL                = 8'h1C;

  // ==========================================================================
  // Field widths and reset values
  localparam int          FB_DIV_W     = 18;
  localparam int          FRAC_W       = 24;
  localparam int          REF_DIV_W    = 16;
  localparam logic [17:0] FB_DIV_RST   = 18'h00010;
  localparam logic [23:0] FRACTION_NUMERATOR_RST = 24'h000000;
  localparam logic [23:0] FRACTION_DENOMINATOR_RST = 24'h000000;
  localparam logic [15:0] REF_DIV_RST  = 16'h0001;
  localparam logic [1:0]  PWR_SEL_RST  = 2'h0;
  localparam logic [1:0]  DITHER_RST   = 2'h0;
  localparam logic [2:0]  ORDER_RST    = 3'h0;
  localparam logic [24:0] FIXED_DEN    = 25'h1000000;

  // ==========================================================================
  // Bit positions
  localparam int SOFT_RESET_BIT = 2;
  localparam int FB_HIGH_LSB    = 0;
  localparam int DITHER_LSB     = 2;
  localparam int ORDER_LSB      = 4;
  localparam int DOUBLER_BIT    = 0;
  localparam int RAMP_EN_BIT    = 0;

  // ==========================================================================
  // Codes
  localparam logic [1:0] PWR_FORCE_DOWN = 2'h0;
  localparam logic [1:0] PWR_FORCE_UP   = 2'h1;
  localparam logic [1:0] PWR_FOLLOW_PIN = 2'h2;
  localparam logic [2:0] ORDER_MAX      = 3'h4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pdc_pkg

/* File: pdc_regs_tb.sv */
/*
  Self-checking bench for the divider configuration register bank.
  Assumes pdc_pkg and pdc_regs are compiled first; the bench is the AXI4-Lite master.
*/
`timescale 1ns/10ps

// ============================================================================
// Compare macro
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end

module pdc_regs_tb
  import pdc_pkg::*;
;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdat;
    logic [7:0] rst;
  } pdc_row_t;

  // Numerator stays below denominator, as software is asked to keep it
  localparam pdc_row_t ROWS [14] = '{
    '{8'h08, 8'h02, 8'h00}, '{8'h40, 8'h34, 8'h10}, '{8'h44, 8'h12, 8'h00},
    '{8'h48, 8'h43, 8'h00}, '{8'h4C, 8'h11, 8'h00}, '{8'h50, 8'h22, 8'h00},
    '{8'h54, 8'h33, 8'h00}, '{8'h58, 8'h44, 8'h00}, '{8'h5C, 8'h55, 8'h00},
    '{8'h60, 8'h66, 8'h00}, '{8'h64, 8'h00, 8'h01}, '{8'h68, 8'h02, 8'h00},
    '{8'h6C, 8'h01, 8'h00}, '{8'h70, 8'h00, 8'h00}};

  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, chip_enable, power_up, ramp_start, ramp_enable;
  logic        modulator_order_reserved, reference_bypass, reference_doubler_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, modulator_dither_level;
  logic [2:0]  modulator_order_select;
  logic [17:0] feedback_divide;
  logic [23:0] fraction_numerator;
  logic [24:0] effective_denominator;
  logic [15:0] reference_divide;
  int          failures, cmp_count, ramp_cnt, snap;

  pdc_regs DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .chip_enable(chip_enable),
    .power_up(power_up), .feedback_divide(feedback_divide), .ramp_start(ramp_start),
    .ramp_enable(ramp_enable), .modulator_dither_level(modulator_dither_level),
    .modulator_order_select(modulator_order_select),
    .modulator_order_reserved(modulator_order_reserved),
    .fraction_numerator(fraction_numerator), .effective_denominator(effective_denominator),
    .reference_divide(reference_divide), .reference_bypass(reference_bypass),
    .reference_doubler_enable(reference_doubler_enable)
  );

  // ==========================================================================
  // Clock, pulse counter and watchdog
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Counting every high cycle makes a stuck-high start visible as an extra count
  always @(posedge aclk) begin
    if (ramp_start === 1'b1) ramp_cnt++;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    stop_test();
  end

  // ==========================================================================
  // Bus tasks; bready and rready stay high, so no handshake signal is driven twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= {a[7:2], 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    `CHK("bresp", er, s_axi_bresp)
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    `CHK("rdata", {24'h000000, e}, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask

  // Literal defaults, so a wrong package constant is caught as well
  task automatic chk_defaults();
    `CHK("power_up", 1'b0, power_up)
    `CHK("feedback_divide", 18'h00010, feedback_divide)
    `CHK("numerator", 24'h000000, fraction_numerator)
    `CHK("denominator", 25'h0000000, effective_denominator)
    `CHK("ref_divide", 16'h0001, reference_divide)
    `CHK("bypass", 1'b1, reference_bypass)
    `CHK("dither_order", 5'h00, {modulator_dither_level, modulator_order_select})
    `CHK("doubler_ramp", 3'h0, {reference_doubler_enable, ramp_enable, ramp_start})
    for (int i = 0; i < 14; i++) rd_chk(ROWS[i].addr, ROWS[i].rst, RESP_OKAY);
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
    failures = 0;
    cmp_count = 0;
    ramp_cnt = 0;
    aresetn = 1'b0;
    chip_enable = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_defaults();
    $display("test reset defaults done");
    for (int i = 0; i < 14; i++) begin
      wr(ROWS[i].addr, ROWS[i].wdat, RESP_OKAY);
      rd_chk(ROWS[i].addr, ROWS[i].wdat, RESP_OKAY);
    end
    `CHK("feedback_divide", 18'h31234, feedback_divide)
    `CHK("numerator", 24'h332211, fraction_numerator)
    `CHK("denominator", 25'h0665544, effective_denominator)
    `CHK("ref_divide", 16'h0200, reference_divide)
    `CHK("bypass", 1'b0, reference_bypass)
    `CHK("doubler", 1'b1, reference_doubler_enable)
    $display("test register rows done");
    for (int c = 0; c < 4; c++) begin
      for (int e = 0; e < 2; e++) begin
        @(posedge aclk);
        chip_enable <= e[0];
        wr(8'h08, c[7:0], RESP_OKAY);
        @(posedge aclk);
        `CHK("power_up", (c == 1) || (c == 2 && e == 1), power_up)
      end
    end
    $display("test power states done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h48, {1'b0, i[2:0], i[1:0], 2'b11}, RESP_OKAY);
      @(posedge aclk);
      `CHK("order", i[2:0], modulator_order_select)
      `CHK("dither", i[1:0], modulator_dither_level)
      `CHK("order_reserved", i > 4, modulator_order_reserved)
      `CHK("fb_high", 2'h3, feedback_divide[17:16])
    end
    $display("test modulator codes done");
    snap = ramp_cnt;
    wr(8'h40, 8'h20, RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK("ramp_start_low", snap + 1, ramp_cnt)
    wr(8'h44, 8'h01, RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK("ramp_start_mid", snap + 1, ramp_cnt)
    wr(8'h70, 8'h01, RESP_OKAY);
    @(posedge aclk);
    `CHK("fixed_den", 25'h1000000, effective_denominator)
    wr(8'h70, 8'h00, RESP_OKAY);
    @(posedge aclk);
    `CHK("prog_den", 25'h0665544, effective_denominator)
    $display("test ramp start and denominator done");
    wr(8'h7C, 8'hAA, RESP_SLVERR);
    rd_chk(8'h7C, 8'h00, RESP_SLVERR);
    rd_chk(8'h00, 8'h00, RESP_SLVERR);
    $display("test unmapped access done");
    // Power bits ride along to show the same write cannot power the device up
    @(posedge aclk);
    chip_enable <= 1'b1;
    wr(8'h08, 8'h05, RESP_OKAY);
    @(posedge aclk);
    chk_defaults();
    $display("test soft reset done");
    // Hardware reset in mid-run, right after a store and a ramp start
    wr(8'h40, 8'h77, RESP_OKAY);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_defaults();
    $display("test mid-run reset done");
    stop_test();
  end
endmodule // pdc_regs_tb
